// ### design/sdi_error_correction_insert.sv
/*
  in-line correction stage: code remap, preamble expansion, trs rewrite,
  anc checksum and edh crc insertion, plus the processing-disable register.
  assumes flywheel timing inputs are aligned to the data in word_in and that the
  register port is the device's host port seen as a word-wide strobe port.
*/
`timescale 1ns/1ns
`default_nettype none
module sdi_error_correction_insert (
  input  wire logic                clk_in,            // 27 mhz pclk domain
  input  wire logic                rst_in,            // sync reset
  input  wire logic                smpte_mode_in,     // stream is smpte
  input  wire logic                proc_enable_pin_in,// processing enable pin
  input  wire logic                flywheel_on_in,    // flywheel enable pin
  input  wire logic                edh_flag_refresh_in,// edh_flag_refresh control
  input  wire sdi_fix_pkg::word_s  word_in,           // stream word and timing
  input  wire logic                reg_wr_in,         // register write strobe
  input  wire logic                reg_rd_in,         // register read strobe
  input  wire logic [7:0]          reg_addr_in,       // register address
  input  wire logic [15:0]         reg_wdata_in,      // register write data
  output logic      [15:0]         reg_rdata_out,     // read data, next cycle
  output logic      [9:0]          vid_out,           // corrected word
  output logic                     h_sync_out,        // horizontal sync
  output logic                     trs_err_out,       // trs error pulse
  output logic                     picture_crc_valid_seen_out, // rx ap v
  output logic                     field_crc_valid_seen_out,   // rx ff v
  output sdi_fix_pkg::fifo_mode_e  fifo_mode_out,     // line fifo mode
  output logic                     anc_extract_busy_out // extraction running
);
  logic [15:0]              proc_disable_reg;
  logic [15:0]              filter_a;
  sdi_fix_pkg::word_s       s0, s1, s2;
  logic [1:0]               pre_cnt_ff;
  logic                     pre_trs_ff;
  logic [9:0]               prev1_ff, prev2_ff;
  sdi_fix_pkg::anc_state_e  anc_st_ff, nxt_anc_st;
  logic [8:0]               sum_ff;
  logic [7:0]               did_ff, sdid_ff, cnt_ff;
  logic [3:0]               idx_ff;
  logic                     mis_ap_ff, mis_ff_ff;
  logic [15:0]              ap_crc, ff_crc, ap_hold_ff, ff_hold_ff;
  logic                     h_trs_ff;
  logic                     en, remap_on, trs_on, pre_start;
  logic                     is_edh, edh_on, sum_fix, filt_ok, snap;
  logic [9:0]               w0, w1, w_fin;
  logic [7:0]               edh_byte, edh_cmp;
  logic [8:0]               w_sum;

  function automatic logic is_hi(input logic [9:0] d);
    return d >= sdi_fix_pkg::CODE_HI_MIN;
  endfunction : is_hi

  function automatic logic is_lo(input logic [9:0] d);
    return d <= sdi_fix_pkg::CODE_LO_MAX;
  endfunction : is_lo

  // anc word: b8 even parity of b7..b0, b9 its inverse
  function automatic logic [9:0] anc_word(input logic [7:0] b);
    return {~(^b), ^b, b};
  endfunction : anc_word

  // global gates
  assign en       = smpte_mode_in & proc_enable_pin_in;
  assign remap_on = en & ~proc_disable_reg[sdi_fix_pkg::B_REMAP_OFF];
  assign trs_on   = en & flywheel_on_in
                    & ~proc_disable_reg[sdi_fix_pkg::B_TRS_OFF];

  // register writes; unused bits never stored
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      proc_disable_reg <= sdi_fix_pkg::PROC_RST;
      filter_a         <= sdi_fix_pkg::FILTER_RST;
    end else if (reg_wr_in) begin
      if (reg_addr_in == sdi_fix_pkg::ADDR_PROC_DIS) begin
        proc_disable_reg <= reg_wdata_in & sdi_fix_pkg::PROC_WMASK;
      end
      if (reg_addr_in == sdi_fix_pkg::ADDR_FILTER_A) begin
        filter_a <= reg_wdata_in;
      end
    end
  end

  // registered read port; unmapped addresses answer zero
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      reg_rdata_out <= 16'h0000;
    end else if (reg_rd_in) begin
      unique case (reg_addr_in)
        sdi_fix_pkg::ADDR_PROC_DIS: reg_rdata_out <= proc_disable_reg;
        sdi_fix_pkg::ADDR_FILTER_A: reg_rdata_out <= filter_a;
        default:                    reg_rdata_out <= 16'h0000;
      endcase
    end
  end

  assign fifo_mode_out = sdi_fix_pkg::fifo_mode_e'(
    proc_disable_reg[sdi_fix_pkg::B_MODE_HI:sdi_fix_pkg::B_MODE_LO]);

  // extraction latches on the start bit and only reset or a mode change away from anc ends it
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      anc_extract_busy_out <= 1'b0;
    end else if (fifo_mode_out != sdi_fix_pkg::FM_ANC) begin
      anc_extract_busy_out <= 1'b0;
    end else if (proc_disable_reg[sdi_fix_pkg::B_GO]) begin
      anc_extract_busy_out <= 1'b1;
    end
  end

  // three-word look-ahead so preambles are seen before they leave
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      s0 <= '0;
      s1 <= '0;
      s2 <= '0;
    end else begin
      s0 <= word_in;
      s1 <= s0;
      s2 <= s1;
    end
  end

  // 8-bit preamble spotted outside the picture: hi-lo-lo or lo-hi-hi
  assign pre_start = remap_on & ~s2.active & (pre_cnt_ff == 2'h0)
                     & ((is_hi(s2.data) & is_lo(s1.data) & is_lo(s0.data))
                     | (is_lo(s2.data) & is_hi(s1.data) & is_hi(s0.data)));

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      pre_cnt_ff <= 2'h0;
      pre_trs_ff <= 1'b0;
    end else if (pre_start) begin
      pre_cnt_ff <= sdi_fix_pkg::PRE_LEN;
      pre_trs_ff <= is_hi(s2.data);
    end else if (pre_cnt_ff != 2'h0) begin
      pre_cnt_ff <= pre_cnt_ff - 2'h1;
    end
  end

  // remap and preamble expansion
  always_comb begin
    w0 = s2.data;
    if (pre_start) begin
      w0 = is_hi(s2.data) ? sdi_fix_pkg::CODE_ONES : sdi_fix_pkg::CODE_ZERO;
    end else if (remap_on && pre_cnt_ff != 2'h0) begin
      w0 = pre_trs_ff ? sdi_fix_pkg::CODE_ZERO : sdi_fix_pkg::CODE_ONES;
    end else if (remap_on && s2.active && is_hi(s2.data)) begin
      w0 = sdi_fix_pkg::CODE_HI_REP;
    end else if (remap_on && s2.active && is_lo(s2.data)) begin
      w0 = sdi_fix_pkg::CODE_LO_REP;
    end
  end

  // trs rewrite from flywheel h; received f and v kept as they are
  always_comb begin
    w1 = w0;
    if (trs_on && s2.trs) begin
      unique case (s2.trs_idx)
        2'h0:    w1 = sdi_fix_pkg::CODE_ONES;
        2'h1:    w1 = sdi_fix_pkg::CODE_ZERO;
        2'h2:    w1 = sdi_fix_pkg::CODE_ZERO;
        default: w1 = {1'b1, s2.data[8], s2.data[7], s2.eav,
                       s2.data[7] ^ s2.eav, s2.data[8] ^ s2.eav,
                       s2.data[8] ^ s2.data[7],
                       s2.data[8] ^ s2.data[7] ^ s2.eav, 2'b00};
      endcase
    end
  end

  // trs error: h disagrees with flywheel, or protection bits broken
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      trs_err_out <= 1'b0;
    end else begin
      trs_err_out <= s2.trs && s2.trs_idx == sdi_fix_pkg::TRS_XYZ
        && ((flywheel_on_in && s2.data[6] != s2.eav)
        || s2.data[5:2] != {s2.data[7] ^ s2.data[6], s2.data[8] ^ s2.data[6],
                            s2.data[8] ^ s2.data[7],
                            s2.data[8] ^ s2.data[7] ^ s2.data[6]}
        || !s2.data[9]);
    end
  end

  // packet classification
  assign is_edh  = did_ff == sdi_fix_pkg::EDH_DID;
  assign edh_on  = en & ~proc_disable_reg[sdi_fix_pkg::B_EDH_OFF] & is_edh;
  assign filt_ok = (filter_a == 16'h0000) || (filter_a == {did_ff, sdid_ff});
  assign sum_fix = is_edh ? edh_on
                 : en & ~proc_disable_reg[sdi_fix_pkg::B_ANC_OFF] & filt_ok;

  // edh crc byte for the current user word; v bits forced on
  always_comb begin
    edh_byte = w1[7:0];
    edh_cmp  = 8'hFF;
    unique case (idx_ff)
      4'h0: edh_byte = {ap_hold_ff[5:0], 2'b00};
      4'h1: edh_byte = {ap_hold_ff[11:6], 2'b00};
      sdi_fix_pkg::EDH_AP_V_IDX: edh_byte = {1'b1, 1'b0, ap_hold_ff[15:12], 2'b00};
      4'h3: edh_byte = {ff_hold_ff[5:0], 2'b00};
      4'h4: edh_byte = {ff_hold_ff[11:6], 2'b00};
      sdi_fix_pkg::EDH_FF_V_IDX: edh_byte = {1'b1, 1'b0, ff_hold_ff[15:12], 2'b00};
      sdi_fix_pkg::EDH_AP_FLAGS: edh_byte = w1[7:0]
        | ((edh_flag_refresh_in && mis_ap_ff) ? 8'h01 << sdi_fix_pkg::EDH_ERR_BIT : 8'h00);
      sdi_fix_pkg::EDH_FF_FLAGS: edh_byte = w1[7:0]
        | ((edh_flag_refresh_in && mis_ff_ff) ? 8'h01 << sdi_fix_pkg::EDH_ERR_BIT : 8'h00);
      default: edh_byte = w1[7:0];
    endcase
    if (idx_ff == sdi_fix_pkg::EDH_AP_V_IDX || idx_ff == sdi_fix_pkg::EDH_FF_V_IDX) begin
      edh_cmp = 8'h7F;
    end
  end

  // final word selection
  always_comb begin
    w_fin = w1;
    if (anc_st_ff == sdi_fix_pkg::AS_UDW && edh_on) begin
      w_fin = anc_word(edh_byte);
    end else if (anc_st_ff == sdi_fix_pkg::AS_SUM && sum_fix) begin
      w_fin = {~sum_ff[8], sum_ff};
    end
  end
  assign w_sum = sum_ff + w_fin[8:0];

  // anc packet walker on the corrected stream
  always_comb begin
    nxt_anc_st = anc_st_ff;
    unique case (anc_st_ff)
      sdi_fix_pkg::AS_IDLE:
        if (prev2_ff == sdi_fix_pkg::CODE_ZERO && prev1_ff == sdi_fix_pkg::CODE_ONES
            && w1 == sdi_fix_pkg::CODE_ONES) begin
          nxt_anc_st = sdi_fix_pkg::AS_DID;
        end
      sdi_fix_pkg::AS_DID:  nxt_anc_st = sdi_fix_pkg::AS_SDID;
      sdi_fix_pkg::AS_SDID: nxt_anc_st = sdi_fix_pkg::AS_DC;
      sdi_fix_pkg::AS_DC:
        nxt_anc_st = (w1[7:0] == 8'h00) ? sdi_fix_pkg::AS_SUM : sdi_fix_pkg::AS_UDW;
      sdi_fix_pkg::AS_UDW:
        if (cnt_ff == 8'h01) begin
          nxt_anc_st = sdi_fix_pkg::AS_SUM;
        end
      sdi_fix_pkg::AS_SUM:  nxt_anc_st = sdi_fix_pkg::AS_IDLE;
      default:              nxt_anc_st = sdi_fix_pkg::AS_IDLE;
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      anc_st_ff <= sdi_fix_pkg::AS_IDLE;
    end else begin
      anc_st_ff <= nxt_anc_st;
    end
  end

  // checksum, header capture and user word count
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      sum_ff  <= 9'h000;
      did_ff  <= 8'h00;
      sdid_ff <= 8'h00;
      cnt_ff  <= 8'h00;
      idx_ff  <= 4'h0;
    end else begin
      unique case (anc_st_ff)
        sdi_fix_pkg::AS_DID: begin
          sum_ff <= w1[8:0];
          did_ff <= w1[7:0];
        end
        sdi_fix_pkg::AS_SDID: begin
          sum_ff  <= w_sum;
          sdid_ff <= w1[7:0];
        end
        sdi_fix_pkg::AS_DC: begin
          sum_ff <= w_sum;
          cnt_ff <= w1[7:0];
          idx_ff <= 4'h0;
        end
        sdi_fix_pkg::AS_UDW: begin
          sum_ff <= w_sum;
          cnt_ff <= cnt_ff - 8'h01;
          idx_ff <= (idx_ff == 4'hF) ? idx_ff : idx_ff + 4'h1;
        end
        default: sum_ff <= sum_ff;
      endcase
    end
  end

  // received edh crc mismatch and received v flags
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      mis_ap_ff                  <= 1'b0;
      mis_ff_ff                  <= 1'b0;
      picture_crc_valid_seen_out <= 1'b0;
      field_crc_valid_seen_out   <= 1'b0;
    end else if (anc_st_ff == sdi_fix_pkg::AS_DC) begin
      mis_ap_ff <= 1'b0;
      mis_ff_ff <= 1'b0;
    end else if (anc_st_ff == sdi_fix_pkg::AS_UDW && is_edh) begin
      if (idx_ff <= sdi_fix_pkg::EDH_AP_V_IDX && ((w1[7:0] ^ edh_byte) & edh_cmp) != 8'h00) begin
        mis_ap_ff <= 1'b1;
      end
      if (idx_ff > sdi_fix_pkg::EDH_AP_V_IDX && idx_ff <= sdi_fix_pkg::EDH_FF_V_IDX
          && ((w1[7:0] ^ edh_byte) & edh_cmp) != 8'h00) begin
        mis_ff_ff <= 1'b1;
      end
      if (idx_ff == sdi_fix_pkg::EDH_AP_V_IDX) begin
        picture_crc_valid_seen_out <= w1[sdi_fix_pkg::EDH_V_BIT];
      end
      if (idx_ff == sdi_fix_pkg::EDH_FF_V_IDX) begin
        field_crc_valid_seen_out <= w1[sdi_fix_pkg::EDH_V_BIT];
      end
    end
  end

  // field crcs: snapshot and restart when an edh packet begins
  assign snap = anc_st_ff == sdi_fix_pkg::AS_DID && w1[7:0] == sdi_fix_pkg::EDH_DID;

  sdi_crc16 #(.W(sdi_fix_pkg::DW)) u_ap_crc (
    .clk_in  (clk_in),
    .rst_in  (rst_in),
    .clr_in  (snap),
    .upd_in  (s2.ap_rng),
    .word_in (w_fin),
    .crc_out (ap_crc)
  );

  sdi_crc16 #(.W(sdi_fix_pkg::DW)) u_ff_crc (
    .clk_in  (clk_in),
    .rst_in  (rst_in),
    .clr_in  (snap),
    .upd_in  (s2.ff_rng),
    .word_in (w_fin),
    .crc_out (ff_crc)
  );

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      ap_hold_ff <= 16'h0000;
      ff_hold_ff <= 16'h0000;
    end else if (snap) begin
      ap_hold_ff <= ap_crc;
      ff_hold_ff <= ff_crc;
    end
  end

  // output word, preamble history and h sync style
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      vid_out    <= 10'h000;
      prev1_ff   <= 10'h000;
      prev2_ff   <= 10'h000;
      h_trs_ff   <= 1'b0;
      h_sync_out <= 1'b0;
    end else begin
      vid_out  <= w_fin;
      prev1_ff <= w1;
      prev2_ff <= prev1_ff;
      if (s2.trs && s2.trs_idx == sdi_fix_pkg::TRS_XYZ) begin
        h_trs_ff <= s2.data[6];
      end
      h_sync_out <= proc_disable_reg[sdi_fix_pkg::B_HCFG] ? h_trs_ff : s2.hblank;
    end
  end

  // checks
  sequence s_plain_pic;
    remap_on && s2.active && pre_cnt_ff == 2'h0 && !(trs_on && s2.trs)
      && anc_st_ff == sdi_fix_pkg::AS_IDLE;
  endsequence

  sequence s_xyz_slot;
    trs_on && s2.trs && s2.trs_idx == sdi_fix_pkg::TRS_XYZ
      && anc_st_ff == sdi_fix_pkg::AS_IDLE;
  endsequence

  AST_GATE_OFF: assert property (@(posedge clk_in) disable iff (rst_in)
    !en |=> vid_out == $past(s2.data)) else $error("stream altered while gated off");
  AST_RST_CLEAR: assert property (@(posedge clk_in) disable iff (rst_in)
    $fell(rst_in) |-> proc_disable_reg == sdi_fix_pkg::PROC_RST) else $error("register not cleared");
  AST_GO_HOLD: assert property (@(posedge clk_in) disable iff (rst_in)
    anc_extract_busy_out && fifo_mode_out == sdi_fix_pkg::FM_ANC && !reg_wr_in
      |=> anc_extract_busy_out) else $error("extraction dropped");
  AST_MODE_WR: assert property (@(posedge clk_in) disable iff (rst_in)
    reg_wr_in && reg_addr_in == sdi_fix_pkg::ADDR_PROC_DIS
      |=> fifo_mode_out == $past(reg_wdata_in[8:7])) else $error("fifo mode not taken");
  AST_REMAP_HI: assert property (@(posedge clk_in) disable iff (rst_in)
    s_plain_pic and is_hi(s2.data) |=> vid_out == sdi_fix_pkg::CODE_HI_REP) else $error("high code kept");
  AST_REMAP_LO: assert property (@(posedge clk_in) disable iff (rst_in)
    s_plain_pic and is_lo(s2.data) |=> vid_out == sdi_fix_pkg::CODE_LO_REP) else $error("low code kept");
  AST_TRS_H: assert property (@(posedge clk_in) disable iff (rst_in)
    s_xyz_slot |=> vid_out[6] == $past(s2.eav) && vid_out[8:7] == $past(s2.data[8:7]))
    else $error("trs h not from flywheel");
  AST_UNUSED_ZERO: assert property (@(posedge clk_in) disable iff (rst_in)
    reg_rd_in && reg_addr_in == sdi_fix_pkg::ADDR_PROC_DIS
      |=> (reg_rdata_out & ~sdi_fix_pkg::PROC_WMASK) == 16'h0000) else $error("unused bits set");
  AST_CSUM: assert property (@(posedge clk_in) disable iff (rst_in)
    anc_st_ff == sdi_fix_pkg::AS_SUM && sum_fix |=> vid_out[8:0] == $past(sum_ff)
      && vid_out[9] == !vid_out[8]) else $error("checksum not inserted");
  AST_V_FORCED: assert property (@(posedge clk_in) disable iff (rst_in)
    anc_st_ff == sdi_fix_pkg::AS_UDW && edh_on && idx_ff == sdi_fix_pkg::EDH_AP_V_IDX
      |=> vid_out[sdi_fix_pkg::EDH_V_BIT]) else $error("ap v bit not forced");
endmodule : sdi_error_correction_insert
`default_nettype wire

// ### design/sdi_fix_pkg.sv
/*
  constants, types and register layout shared by the sdi in-line correction stage.
  assumes a 10-bit smpte word stream and a word-wide register port.
*/
package sdi_fix_pkg;
  localparam int          DW            = 10;
  localparam logic [7:0]  ADDR_PROC_DIS = 8'h00;
  localparam logic [7:0]  ADDR_FILTER_A = 8'h01;
  localparam logic [15:0] PROC_RST      = 16'h0000;
  localparam logic [15:0] PROC_WMASK    = 16'h03CF;
  localparam logic [15:0] FILTER_RST    = 16'h0000;
  localparam int          B_TRS_OFF     = 0;
  localparam int          B_ANC_OFF     = 1;
  localparam int          B_EDH_OFF     = 2;
  localparam int          B_REMAP_OFF   = 3;
  localparam int          B_HCFG        = 6;
  localparam int          B_MODE_LO     = 7;
  localparam int          B_MODE_HI     = 8;
  localparam int          B_GO          = 9;
  localparam logic [9:0]  CODE_HI_MIN   = 10'h03FC;
  localparam logic [9:0]  CODE_HI_REP   = 10'h03FB;
  localparam logic [9:0]  CODE_LO_MAX   = 10'h0003;
  localparam logic [9:0]  CODE_LO_REP   = 10'h0004;
  localparam logic [9:0]  CODE_ONES     = 10'h03FF;
  localparam logic [9:0]  CODE_ZERO     = 10'h0000;
  localparam logic [7:0]  EDH_DID       = 8'hF4;
  localparam logic [15:0] CRC_POLY      = 16'h1021;
  localparam logic [3:0]  EDH_AP_V_IDX  = 4'h2;
  localparam logic [3:0]  EDH_FF_V_IDX  = 4'h5;
  localparam logic [3:0]  EDH_AP_FLAGS  = 4'h7;
  localparam logic [3:0]  EDH_FF_FLAGS  = 4'h8;
  localparam int          EDH_V_BIT     = 7;
  localparam int          EDH_ERR_BIT   = 2;
  localparam logic [1:0]  PRE_LEN       = 2'h2;
  localparam logic [1:0]  TRS_XYZ       = 2'h3;

  typedef enum logic [1:0] {
    FM_VIDEO  = 2'b00,
    FM_ASI    = 2'b01,
    FM_ANC    = 2'b10,
    FM_BYPASS = 2'b11
  } fifo_mode_e;

  typedef enum logic [5:0] {
    AS_IDLE = 6'b000001,
    AS_DID  = 6'b000010,
    AS_SDID = 6'b000100,
    AS_DC   = 6'b001000,
    AS_UDW  = 6'b010000,
    AS_SUM  = 6'b100000
  } anc_state_e;

  // one stream word and the flywheel timing aligned to it
  typedef struct packed {
    logic [9:0] data;
    logic       active;
    logic       ap_rng;
    logic       ff_rng;
    logic       trs;
    logic [1:0] trs_idx;
    logic       eav;
    logic       hblank;
  } word_s;
endpackage : sdi_fix_pkg

// ### design/sdi_crc16.sv
/*
  crc-ccitt accumulator over 10-bit words, one word per clock.
  assumes clear wins over update in the same cycle.
*/
`timescale 1ns/1ns
`default_nettype none
module sdi_crc16 #(
  parameter int W = 10
) (
  input  wire logic         clk_in,   // stream clock
  input  wire logic         rst_in,   // sync reset
  input  wire logic         clr_in,   // restart accumulation
  input  wire logic         upd_in,   // word lies in range
  input  wire logic [W-1:0] word_in,  // word to fold in
  output logic      [15:0]  crc_out   // running crc
);
  logic [15:0] nxt_crc;

  // bitwise lfsr, lsb first
  always_comb begin
    nxt_crc = crc_out;
    for (int i = 0; i < W; i++) begin
      if (nxt_crc[15] ^ word_in[i]) begin
        nxt_crc = {nxt_crc[14:0], 1'b0} ^ sdi_fix_pkg::CRC_POLY;
      end else begin
        nxt_crc = {nxt_crc[14:0], 1'b0};
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in || clr_in) begin
      crc_out <= 16'h0000;
    end else if (upd_in) begin
      crc_out <= nxt_crc;
    end
  end
endmodule : sdi_crc16
`default_nettype wire

// ### dv/word_source.sv
/*
  upstream deserializer model: packs one sample and its flywheel timing
  into the stream word. assumes the bench changes its inputs just after
  the rising clock edge, so the word is steady at every sampling edge.
*/
`timescale 1ns/1ns
`default_nettype none
module word_source (
  input  wire logic          data_vld_in, // sample slot carries data
  input  wire logic [9:0]    data_in,     // sample value
  input  wire logic          active_in,   // active picture sample
  input  wire logic          hblank_in,   // active-line blanking level
  input  wire logic          xyz_in,      // data slot is a trs xyz word
  input  wire logic          fly_h_in,    // flywheel h for that xyz word
  output sdi_fix_pkg::word_s word_out     // packed stream word
);
  // only lone xyz slots are modelled, so the lead-in words and the crc
  // ranges stay low; idle slots carry blanking and are never trs slots
  always_comb begin
    word_out         = '0;
    word_out.data    = data_vld_in ? data_in : 10'h0200;
    word_out.active  = active_in;
    word_out.hblank  = hblank_in;
    word_out.trs     = data_vld_in & xyz_in;
    word_out.trs_idx = sdi_fix_pkg::TRS_XYZ;
    word_out.eav     = fly_h_in;
  end
endmodule : word_source
`default_nettype wire

// ### dv/tb.sv
/*
  self-checking bench for the in-line correction stage: register tasks on
  the strobe port and single stream words through the 4-clock pipeline.
  assumes the word_source model stands upstream of the design.
*/
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic                    clk_in = 1'b0;
  logic                    rst_in = 1'b1;
  logic                    smpte_mode_in = 1'b1;
  logic                    proc_enable_pin_in = 1'b1;
  logic                    reg_wr_in = 1'b0;
  logic                    reg_rd_in = 1'b0;
  logic [7:0]              reg_addr_in = 8'h00;
  logic [15:0]             reg_wdata_in = 16'h0000;
  logic                    vld = 1'b0;
  logic [9:0]              dat = 10'h0000;
  logic                    act = 1'b0;
  logic                    hbl = 1'b0;
  logic                    fw = 1'b1;
  logic                    xyz = 1'b0;
  logic                    fh = 1'b0;
  sdi_fix_pkg::word_s      word;
  logic [15:0]             rdata;
  logic [9:0]              vid;
  logic                    hsync;
  logic                    busy;
  logic                    terr;
  logic                    apv;
  logic                    ffv;
  sdi_fix_pkg::fifo_mode_e fmode;
  logic [15:0]             r;
  int                      error_cnt = 0;
  int                      total_checks = 0;
  int                      cycles = 0;
  logic [9:0]              ins [10] = '{10'h03FC, 10'h03FD, 10'h03FE, 10'h03FF, 10'h0000,
                                        10'h0001, 10'h0002, 10'h0003, 10'h03FB, 10'h0004};
  logic [9:0]              exp [10] = '{10'h03FB, 10'h03FB, 10'h03FB, 10'h03FB, 10'h0004,
                                        10'h0004, 10'h0004, 10'h0004, 10'h03FB, 10'h0004};

  always #2 clk_in = ~clk_in;

  word_source src (.data_vld_in(vld), .data_in(dat), .active_in(act), .hblank_in(hbl),
                   .xyz_in(xyz), .fly_h_in(fh), .word_out(word));

  sdi_error_correction_insert dut (
    .clk_in(clk_in), .rst_in(rst_in), .smpte_mode_in(smpte_mode_in),
    .proc_enable_pin_in(proc_enable_pin_in), .flywheel_on_in(fw), .edh_flag_refresh_in(1'b0),
    .word_in(word), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_rdata_out(rdata), .vid_out(vid), .h_sync_out(hsync),
    .trs_err_out(terr), .picture_crc_valid_seen_out(apv), .field_crc_valid_seen_out(ffv),
    .fifo_mode_out(fmode), .anc_extract_busy_out(busy));

  task automatic chk_reg(input logic [15:0] got, input logic [15:0] want);
    total_checks++;
    if (got !== want) begin
      error_cnt++;
      $display("unexpected reg at %0t: got %h want %h", $time, got, want);
    end
  endtask : chk_reg

  task automatic chk_vid(input logic [9:0] got, input logic [9:0] want);
    total_checks++;
    if (got !== want) begin
      error_cnt++;
      $display("unexpected video at %0t: got %h want %h", $time, got, want);
    end
  endtask : chk_vid

  // host write: strobe held for exactly one sampling edge
  task automatic reg_wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_in) #1;
    reg_wr_in    = 1'b1;
    reg_addr_in  = a;
    reg_wdata_in = d;
    @(posedge clk_in) #1;
    reg_wr_in = 1'b0;
  endtask : reg_wr

  // host read: data is registered, so it is valid once the strobe edge has passed
  task automatic reg_rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge clk_in) #1;
    reg_rd_in   = 1'b1;
    reg_addr_in = a;
    @(posedge clk_in) #1;
    reg_rd_in = 1'b0;
    d         = rdata;
  endtask : reg_rd

  // one word, then blanking; the output flop shows it three edges after the sampling edge
  task automatic send(input logic [9:0] d, input logic a, input logic h);
    @(posedge clk_in) #1;
    vld = 1'b1;
    dat = d;
    act = a;
    hbl = h;
    @(posedge clk_in) #1;
    vld = 1'b0;
    act = 1'b0;
    hbl = 1'b0;
    repeat (3) @(posedge clk_in);
    #1;
  endtask : send

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : print_verdict

  // the tests need about 130 cycles; a hang is cut at 5000
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 5000) begin
      error_cnt++;
      print_verdict();
    end
  end

  initial begin
    repeat (3) @(posedge clk_in);
    #1 rst_in = 1'b0;
    reg_rd(8'h00, r);
    chk_reg(r, 16'h0000);
    chk_reg({14'h0000, fmode}, 16'h0000);
    chk_reg({14'h0000, apv, ffv}, 16'h0000);
    reg_wr(8'h00, 16'hFFFF);
    reg_rd(8'h00, r);
    chk_reg(r, 16'h03CF);
    for (int m = 0; m < 4; m++) begin
      reg_wr(8'h00, 16'(m) << 7);
      chk_reg({14'h0000, fmode}, 16'(m));
    end
    $display("test register done");
    reg_wr(8'h00, 16'h0000);
    for (int i = 0; i < 10; i++) begin
      send(ins[i], 1'b1, 1'b0);
      chk_vid(vid, exp[i]);
    end
    reg_wr(8'h00, 16'h0008);
    send(10'h03FE, 1'b1, 1'b0);
    chk_vid(vid, 10'h03FE);
    reg_wr(8'h00, 16'h0000);
    proc_enable_pin_in = 1'b0;
    send(10'h0001, 1'b1, 1'b0);
    chk_vid(vid, 10'h0001);
    proc_enable_pin_in = 1'b1;
    smpte_mode_in      = 1'b0;
    send(10'h03FF, 1'b1, 1'b0);
    chk_vid(vid, 10'h03FF);
    smpte_mode_in = 1'b1;
    $display("test remap done");
    // xyz words: f/v kept, h from flywheel, protection rebuilt
    xyz = 1'b1;
    fh  = 1'b1;
    send(10'h0380, 1'b0, 1'b0);
    chk_vid(vid, 10'h03C4);
    chk_reg({15'h0000, terr}, 16'h0001);
    fh = 1'b0;
    send(10'h0200, 1'b0, 1'b0);
    chk_vid(vid, 10'h0200);
    chk_reg({15'h0000, terr}, 16'h0000);
    fw = 1'b0;
    send(10'h0274, 1'b0, 1'b0);
    chk_vid(vid, 10'h0274);
    chk_reg({15'h0000, terr}, 16'h0000);
    fw  = 1'b1;
    xyz = 1'b0;
    $display("test trs done");
    send(10'h0200, 1'b0, 1'b1);
    chk_reg({15'h0000, hsync}, 16'h0001);
    @(posedge clk_in) #1 chk_reg({15'h0000, hsync}, 16'h0000);
    reg_wr(8'h00, 16'h0040);
    send(10'h0200, 1'b0, 1'b0);
    chk_reg({15'h0000, hsync}, 16'h0001);
    $display("test hsync done");
    reg_wr(8'h00, 16'h0100);
    repeat (2) @(posedge clk_in);
    #1 chk_reg({15'h0000, busy}, 16'h0000);
    reg_wr(8'h00, 16'h0300);
    repeat (2) @(posedge clk_in);
    #1 chk_reg({15'h0000, busy}, 16'h0001);
    reg_wr(8'h00, 16'h0100);
    repeat (2) @(posedge clk_in);
    #1 chk_reg({15'h0000, busy}, 16'h0001);
    reg_wr(8'h00, 16'h0000);
    repeat (2) @(posedge clk_in);
    #1 chk_reg({15'h0000, busy}, 16'h0000);
    $display("test extract done");
    print_verdict();
  end
endmodule : tb
`default_nettype wire
